// file: dv/dbrc_tb.sv
// Purpose: self-checking bench for the loop, brown-out and regulator registers
// Assumes: classic wishbone master, one clock, analog inputs pass a two-flop sync
// Notes: checks after analog changes wait 4 cycles to cover the sync lag
`timescale 1ns/1ps
module testbench;
  import dbrc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i, por_rst_i, bod_rst_i, cyc, stb, we, wb_ack_o;
  logic [3:0] adr, sel, vtrim, v_trim;
  logic [31:0] wdat, rdat, q;
  logic closed, sdone, fcal, bload, bhyst, vload, core_ab, in_ab, core_raw, in_raw, von, vok, slp;
  logic [15:0] rerr;
  logic [4:0] win;
  logic [1:0] bctrl;
  logic [5:0] blev, b_lev;
  logic snap_req, rdy, b_en, b_rst, b_irq, b_hysteresis_enable, core_por, in_por, core_den, in_den, v_en, v_deep, v_pd;
  logic [2:0] v_sel;
  logic [2:0] bexp [3];
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  dbrc_regs dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .por_rst_i(por_rst_i), .bod_rst_i(bod_rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(wb_ack_o),
    .loop_closed_i(closed), .loop_ratio_error_i(rerr), .loop_window_i(win), .loop_snap_done_i(sdone),
    .loop_snap_req_o(snap_req), .loop_ready_flag_o(rdy),
    .flash_cal_i(fcal), .bod_fuse_load_i(bload), .bod_fuse_ctrl_i(bctrl), .bod_fuse_hysteresis_enable_i(bhyst),
    .bod_fuse_level_i(blev), .vreg_fuse_load_i(vload), .vreg_fuse_trim_i(vtrim),
    .bod_enable_o(b_en), .bod_reset_en_o(b_rst), .bod_irq_en_o(b_irq), .bod_hysteresis_enable_o(b_hysteresis_enable), .bod_level_o(b_lev),
    .core_above_i(core_ab), .input_above_i(in_ab), .core_por_raw_i(core_raw), .input_por_raw_i(in_raw),
    .vreg_on_i(von), .vreg_stable_i(vok), .sleep_low_power_i(slp),
    .core_por_o(core_por), .input_por_o(in_por), .core_det_en_o(core_den), .input_det_en_o(in_den),
    .vreg_en_o(v_en), .vreg_deep_o(v_deep), .vreg_pulldown_o(v_pd), .vreg_trim_o(v_trim), .vreg_sel_o(v_sel)
  );
  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // hold the request until ack is sampled high, then release
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      i++;
    end
    while (wb_ack_o !== 1'b1 && i < 16);
    q = rdat;
    if (i >= 16)
      chk(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask
  // extra cycles after release let the synced analog inputs settle
  task automatic do_reset(input logic p, input logic b);
    @(posedge clk_i);
    rst_i <= 1'b1;
    por_rst_i <= p;
    bod_rst_i <= b;
    tick(20);
    rst_i <= 1'b0;
    por_rst_i <= 1'b0;
    bod_rst_i <= 1'b0;
    tick(4);
  endtask
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {rst_i, por_rst_i, bod_rst_i, cyc, stb, we, closed, sdone, fcal, bload, bhyst, vload} = '0;
    {core_ab, in_ab, core_raw, in_raw, von, vok, slp, adr, vtrim, wdat, rerr, win, bctrl, blev} = '0;
    sel = 4'hF;
    bexp = '{3'b000, 3'b111, 3'b101};
    do_reset(1'b1, 1'b0);
    rd(DBRC_OFF_VREG, 32'h006C_0020);
    rd(DBRC_OFF_BOD, 32'h0000_0000);
    rd(DBRC_OFF_SYNC, 32'h0000_0000);
    rd(4'h2, 32'h0000_0000);
    xfer(DBRC_OFF_RATIO, 1'b1, 32'hFFFF_FFFF);
    rd(DBRC_OFF_RATIO, 32'h0000_0000);
    chk(rdy, 1'b1);
    $display("test reset done");
    bctrl <= 2'h1;
    bhyst <= 1'b1;
    blev <= 6'h15;
    bload <= 1'b1;
    tick(1);
    bload <= 1'b0;
    rd(DBRC_OFF_BOD, 32'h0001_0155);
    chk(b_hysteresis_enable, 1'b1);
    for (int c = 0; c < 3; c++)
    begin
      xfer(DBRC_OFF_BOD, 1'b1, 32'h0001_0015 | (32'(c) << 8));
      chk({b_en, b_rst, b_irq}, bexp[c]);
      chk({b_hysteresis_enable, b_lev}, 7'h15);
    end
    xfer(DBRC_OFF_BOD, 1'b1, 32'h8001_0102);
    xfer(DBRC_OFF_BOD, 1'b1, 32'h0001_0000);
    rd(DBRC_OFF_BOD, 32'h8001_0102);
    do_reset(1'b0, 1'b1);
    bload <= 1'b1;
    tick(1);
    bload <= 1'b0;
    rd(DBRC_OFF_BOD, 32'h8001_0000);
    fcal <= 1'b1;
    tick(1);
    fcal <= 1'b0;
    rd(DBRC_OFF_BOD, 32'h0001_0000);
    do_reset(1'b0, 1'b0);
    rd(DBRC_OFF_BOD, 32'h0000_0000);
    $display("test brown-out done");
    slp <= 1'b1;
    xfer(DBRC_OFF_VREG, 1'b1, 32'h43EA_00E2);
    rd(DBRC_OFF_VREG, 32'h40E2_0022);
    chk({v_pd, core_den, in_den, v_en, v_deep, v_sel}, 8'hD2);
    {core_raw, in_raw, core_ab, in_ab, von, vok} <= 6'h3F;
    tick(4);
    chk({core_por, in_por}, 2'b00);
    rd(DBRC_OFF_VREG, 32'h43E2_00E2);
    xfer(DBRC_OFF_VREG, 1'b1, 32'h0034_0020);
    chk({core_por, in_por, v_deep}, 3'b101);
    xfer(DBRC_OFF_VREG, 1'b1, 32'h0024_0000);
    chk({in_por, v_en, v_pd}, 3'b100);
    rd(DBRC_OFF_VREG, 32'h036C_0080);
    vtrim <= 4'hA;
    vload <= 1'b1;
    tick(1);
    vload <= 1'b0;
    rd(DBRC_OFF_VREG, 32'h036D_0A80);
    chk(v_trim, 4'hA);
    xfer(DBRC_OFF_VREG, 1'b1, 32'h8025_0A20);
    xfer(DBRC_OFF_VREG, 1'b1, 32'h0000_0000);
    rd(DBRC_OFF_VREG, 32'h836D_0AE0);
    do_reset(1'b0, 1'b0);
    rd(DBRC_OFF_VREG, 32'h836D_0AE0);
    do_reset(1'b1, 1'b0);
    rd(DBRC_OFF_VREG, 32'h036C_00E0);
    $display("test regulator done");
    rerr <= 16'hBEEF;
    win <= 5'h1F;
    xfer(DBRC_OFF_SYNC, 1'b1, 32'h0000_0001);
    chk({rdy, snap_req}, 2'b10);
    closed <= 1'b1;
    xfer(DBRC_OFF_SYNC, 1'b1, 32'h0000_0001);
    chk({rdy, snap_req}, 2'b01);
    rd(DBRC_OFF_RATIO, 32'h0000_0000);
    sdone <= 1'b1;
    n = 0;
    while (rdy !== 1'b1 && n < 10)
    begin
      @(posedge clk_i);
      n++;
    end
    sdone <= 1'b0;
    chk({rdy, snap_req}, 2'b10);
    rd(DBRC_OFF_RATIO, 32'hBEEF_001F);
    $display("test snapshot done");
    final_report();
  end
endmodule // testbench

// file: src/dbrc_pkg.sv
// Purpose: constants and carrier types for the loop/brown-out/regulator register slice
// Assumes: classic wishbone, 32-bit data, byte addresses
// Notes: offsets are local to this slice
package dbrc_pkg;
  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] DBRC_OFF_RATIO = 4'h0;
  localparam logic [3:0] DBRC_OFF_SYNC = 4'h4;
  localparam logic [3:0] DBRC_OFF_BOD = 4'h8;
  localparam logic [3:0] DBRC_OFF_VREG = 4'hC;
  localparam logic [3:0] DBRC_OFF_CTRL = 4'h0;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DBRC_LOCK_BIT = 31;
  localparam int DBRC_PD_BIT = 30;
  localparam int DBRC_CORE_VAL_BIT = 25;
  localparam int DBRC_IN_VAL_BIT = 24;
  localparam int DBRC_CORE_MASK_BIT = 23;
  localparam int DBRC_CORE_ST_BIT = 22;
  localparam int DBRC_CORE_EN_BIT = 21;
  localparam int DBRC_IN_MASK_BIT = 20;
  localparam int DBRC_IN_ST_BIT = 19;
  localparam int DBRC_IN_EN_BIT = 18;
  localparam int DBRC_DEEP_BIT = 17;
  localparam int DBRC_DONE_BIT = 16;
  localparam int DBRC_ON_BIT = 7;
  localparam int DBRC_OK_BIT = 6;
  localparam int DBRC_EN_BIT = 5;
  localparam int DBRC_HYS_BIT = 6;
  localparam int DBRC_SYNC_BIT = 0;
  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [1:0] DBRC_BOD_OFF = 2'h0;
  localparam logic [1:0] DBRC_BOD_RESET = 2'h1;
  localparam logic [1:0] DBRC_BOD_IRQ = 2'h2;
  localparam logic [2:0] DBRC_SEL_1V8 = 3'h0;
  localparam logic [3:0] DBRC_TRIM_RST = 4'h0;
  localparam logic [5:0] DBRC_LEVEL_RST = 6'h00;

  typedef enum logic [1:0] {
    DBRC_IDLE = 2'b00,
    DBRC_WAIT = 2'b01,
    DBRC_CAPT = 2'b10
  } dbrc_snap_t;

  typedef struct packed {
    logic [15:0] ratio_error;
    logic [4:0] measure_window_exponent;
  } dbrc_ratio_t;

  typedef struct packed {
    logic store_final_lock;
    logic calibration_done;
    logic [1:0] ctrl;
    logic hysteresis_enable;
    logic [5:0] level;
  } dbrc_bod_t;

  typedef struct packed {
    logic store_final_lock;
    logic output_pulldown;
    logic core_detector_mask;
    logic core_detector_enable;
    logic input_detector_mask;
    logic input_detector_enable;
    logic deep_mode_disable;
    logic calibration_done;
    logic [3:0] trim_value;
    logic enable;
    logic [2:0] output_voltage_select;
  } dbrc_vreg_t;

  typedef struct packed {
    dbrc_snap_t snap;
    logic loop_ready_flag;
    dbrc_ratio_t ratio;
    dbrc_bod_t brownout_control;
    dbrc_vreg_t vreg;
    logic ack;
    logic [31:0] dat;
  } dbrc_state_t;
endpackage

// file: src/dbrc_regs.sv
// Purpose: loop ratio readback, brown-out and regulator control registers
// Assumes: wishbone classic slave, one clock, analog status inputs asynchronous
// Notes: ack comes one cycle after stb, reads registered
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
module dbrc_regs
  import dbrc_pkg::*;
(
  // clock and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic por_rst_i,
  input wire logic bod_rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // frequency loop
  input wire logic loop_closed_i,
  input wire logic [15:0] loop_ratio_error_i,
  input wire logic [4:0] loop_window_i,
  input wire logic loop_snap_done_i,
  output logic loop_snap_req_o,
  output logic loop_ready_flag_o,
  // fuse loading
  input wire logic flash_cal_i,
  input wire logic bod_fuse_load_i,
  input wire logic [1:0] bod_fuse_ctrl_i,
  input wire logic bod_fuse_hysteresis_enable_i,
  input wire logic [5:0] bod_fuse_level_i,
  input wire logic vreg_fuse_load_i,
  input wire logic [3:0] vreg_fuse_trim_i,
  // brown-out detector
  output logic bod_enable_o,
  output logic bod_reset_en_o,
  output logic bod_irq_en_o,
  output logic bod_hysteresis_enable_o,
  output logic [5:0] bod_level_o,
  // regulator and detectors
  input wire logic core_above_i,
  input wire logic input_above_i,
  input wire logic core_por_raw_i,
  input wire logic input_por_raw_i,
  input wire logic vreg_on_i,
  input wire logic vreg_stable_i,
  input wire logic sleep_low_power_i,
  output logic core_por_o,
  output logic input_por_o,
  output logic core_det_en_o,
  output logic input_det_en_o,
  output logic vreg_en_o,
  output logic vreg_deep_o,
  output logic vreg_pulldown_o,
  output logic [3:0] vreg_trim_o,
  output logic [2:0] vreg_sel_o
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  logic [5:0] async_in;
  assign async_in = {core_above_i, input_above_i, vreg_on_i, vreg_stable_i,
                     core_por_raw_i, input_por_raw_i};
  always_ff @(posedge clk_i)
  begin
    sync1_q <= async_in;
    sync2_q <= sync1_q;
  end
  logic core_above_s, input_above_s, vreg_on_s, vreg_ok_s, core_raw_s, input_raw_s;
  assign {core_above_s, input_above_s, vreg_on_s, vreg_ok_s, core_raw_s, input_raw_s} = sync2_q;

  // ****************************************************************
  // state
  // ****************************************************************
  dbrc_state_t s_q;
  dbrc_state_t s_d;
  logic req;
  logic wr;
  logic [31:0] bod_rd;
  logic [31:0] vreg_rd;
  logic [31:0] wmask;
  assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
  assign wr = req && wb_we_i;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  always_comb
  begin
    bod_rd = '0;
    bod_rd[DBRC_LOCK_BIT] = s_q.brownout_control.store_final_lock;
    bod_rd[DBRC_DONE_BIT] = s_q.brownout_control.calibration_done;
    bod_rd[9:8] = s_q.brownout_control.ctrl;
    bod_rd[DBRC_HYS_BIT] = s_q.brownout_control.hysteresis_enable;
    bod_rd[5:0] = s_q.brownout_control.level;
    vreg_rd = '0;
    vreg_rd[DBRC_LOCK_BIT] = s_q.vreg.store_final_lock;
    vreg_rd[DBRC_PD_BIT] = s_q.vreg.output_pulldown;
    vreg_rd[DBRC_CORE_VAL_BIT] = core_above_s;
    vreg_rd[DBRC_IN_VAL_BIT] = input_above_s;
    vreg_rd[DBRC_CORE_MASK_BIT] = s_q.vreg.core_detector_mask;
    vreg_rd[DBRC_CORE_ST_BIT] = s_q.vreg.core_detector_enable;
    vreg_rd[DBRC_CORE_EN_BIT] = s_q.vreg.core_detector_enable;
    vreg_rd[DBRC_IN_MASK_BIT] = s_q.vreg.input_detector_mask;
    vreg_rd[DBRC_IN_ST_BIT] = s_q.vreg.input_detector_enable;
    vreg_rd[DBRC_IN_EN_BIT] = s_q.vreg.input_detector_enable;
    vreg_rd[DBRC_DEEP_BIT] = s_q.vreg.deep_mode_disable;
    vreg_rd[DBRC_DONE_BIT] = s_q.vreg.calibration_done;
    vreg_rd[11:8] = s_q.vreg.trim_value;
    vreg_rd[DBRC_ON_BIT] = vreg_on_s;
    vreg_rd[DBRC_OK_BIT] = vreg_ok_s && s_q.vreg.enable;
    vreg_rd[DBRC_EN_BIT] = s_q.vreg.enable;
    vreg_rd[2:0] = s_q.vreg.output_voltage_select;
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    logic [31:0] wv;
    wv = '0;
    s_d = s_q;
    s_d.ack = req;
    s_d.dat = '0;
    // snapshot handshake with the loop
    unique case (s_q.snap)
      DBRC_IDLE:
      begin
        if (wr && wb_adr_i == DBRC_OFF_SYNC && wb_sel_i[0] && wb_dat_i[DBRC_SYNC_BIT]
            && loop_closed_i)
        begin
          s_d.snap = DBRC_WAIT;
          s_d.loop_ready_flag = 1'b0;
        end
      end
      DBRC_WAIT:
      begin
        if (loop_snap_done_i)
        begin
          s_d.snap = DBRC_CAPT;
        end
      end
      DBRC_CAPT:
      begin
        s_d.ratio.ratio_error = loop_ratio_error_i;
        s_d.ratio.measure_window_exponent = loop_window_i;
        s_d.loop_ready_flag = 1'b1;
        s_d.snap = DBRC_IDLE;
      end
      default:
      begin
        s_d.snap = DBRC_IDLE;
      end
    endcase
    // reads
    if (req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        DBRC_OFF_RATIO: s_d.dat = {s_q.ratio.ratio_error, 11'h000, s_q.ratio.measure_window_exponent};
        DBRC_OFF_BOD: s_d.dat = bod_rd;
        DBRC_OFF_VREG: s_d.dat = vreg_rd;
        default: s_d.dat = '0;
      endcase
    end
    // brown-out writes, ignored once locked
    if (wr && wb_adr_i == DBRC_OFF_BOD && !s_q.brownout_control.store_final_lock)
    begin
      wv = (bod_rd & ~wmask) | (wb_dat_i & wmask);
      s_d.brownout_control.store_final_lock = wv[DBRC_LOCK_BIT];
      s_d.brownout_control.ctrl = wv[9:8];
      s_d.brownout_control.hysteresis_enable = wv[DBRC_HYS_BIT];
      s_d.brownout_control.level = wv[5:0];
    end
    if (bod_fuse_load_i && !s_q.brownout_control.calibration_done)
    begin
      s_d.brownout_control.ctrl = bod_fuse_ctrl_i;
      s_d.brownout_control.hysteresis_enable = bod_fuse_hysteresis_enable_i;
      s_d.brownout_control.level = bod_fuse_level_i;
      s_d.brownout_control.calibration_done = 1'b1;
    end
    if (flash_cal_i)
    begin
      s_d.brownout_control.store_final_lock = 1'b0;
    end
    // regulator writes, ignored once locked
    if (wr && wb_adr_i == DBRC_OFF_VREG && !s_q.vreg.store_final_lock)
    begin
      wv = (vreg_rd & ~wmask) | (wb_dat_i & wmask);
      s_d.vreg.store_final_lock = wv[DBRC_LOCK_BIT];
      s_d.vreg.output_pulldown = wv[DBRC_PD_BIT];
      s_d.vreg.core_detector_mask = wv[DBRC_CORE_MASK_BIT];
      s_d.vreg.core_detector_enable = wv[DBRC_CORE_EN_BIT];
      s_d.vreg.input_detector_mask = wv[DBRC_IN_MASK_BIT];
      s_d.vreg.input_detector_enable = wv[DBRC_IN_EN_BIT];
      s_d.vreg.deep_mode_disable = wv[DBRC_DEEP_BIT];
      s_d.vreg.trim_value = wv[11:8];
      s_d.vreg.enable = wv[DBRC_EN_BIT];
      s_d.vreg.output_voltage_select = wv[2:0];
    end
    if (vreg_fuse_load_i && !s_q.vreg.calibration_done)
    begin
      s_d.vreg.trim_value = vreg_fuse_trim_i;
      s_d.vreg.calibration_done = 1'b1;
    end
  end

  // ****************************************************************
  // registers and reset flavours
  // ****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_q.snap <= DBRC_IDLE;
      s_q.loop_ready_flag <= 1'b1;
      s_q.ratio <= '0;
      s_q.ack <= 1'b0;
      s_q.dat <= '0;
      // brown-out reset keeps lock and fuse-done so fuses are not reloaded
      if (!bod_rst_i)
      begin
        s_q.brownout_control.store_final_lock <= 1'b0;
        s_q.brownout_control.calibration_done <= 1'b0;
      end
      s_q.brownout_control.ctrl <= DBRC_BOD_OFF;
      s_q.brownout_control.hysteresis_enable <= 1'b0;
      s_q.brownout_control.level <= DBRC_LEVEL_RST;
      // regulator fields survive all but power-on reset
      if (por_rst_i)
      begin
        s_q.vreg <= '0;
        s_q.vreg.core_detector_enable <= 1'b1;
        s_q.vreg.input_detector_enable <= 1'b1;
        s_q.vreg.trim_value <= DBRC_TRIM_RST;
        s_q.vreg.enable <= 1'b1;
        s_q.vreg.output_voltage_select <= DBRC_SEL_1V8;
      end
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign loop_snap_req_o = (s_q.snap == DBRC_WAIT);
  assign loop_ready_flag_o = s_q.loop_ready_flag;
  assign bod_enable_o = (s_q.brownout_control.ctrl == DBRC_BOD_RESET) || (s_q.brownout_control.ctrl == DBRC_BOD_IRQ);
  assign bod_reset_en_o = (s_q.brownout_control.ctrl == DBRC_BOD_RESET);
  assign bod_irq_en_o = bod_enable_o;
  assign bod_hysteresis_enable_o = s_q.brownout_control.hysteresis_enable;
  assign bod_level_o = s_q.brownout_control.level;
  assign core_por_o = core_raw_s && s_q.vreg.core_detector_enable && !s_q.vreg.core_detector_mask;
  assign input_por_o = input_raw_s && s_q.vreg.input_detector_enable && !s_q.vreg.input_detector_mask;
  assign core_det_en_o = s_q.vreg.core_detector_enable;
  assign input_det_en_o = s_q.vreg.input_detector_enable;
  assign vreg_en_o = s_q.vreg.enable;
  assign vreg_deep_o = sleep_low_power_i && !s_q.vreg.deep_mode_disable;
  assign vreg_pulldown_o = s_q.vreg.output_pulldown;
  assign vreg_trim_o = s_q.vreg.trim_value;
  assign vreg_sel_o = s_q.vreg.output_voltage_select;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
  a_bod_locked_hold: assert property (s_q.brownout_control.store_final_lock && !flash_cal_i && !bod_fuse_load_i
    |=> $stable(s_q.brownout_control))
    else $error("locked brownout register changed");
  a_vreg_locked_hold: assert property (s_q.vreg.store_final_lock && !vreg_fuse_load_i |=> $stable(s_q.vreg))
    else $error("locked regulator register changed");
  a_ready_after_sync: assert property (wr && wb_adr_i == DBRC_OFF_SYNC && wb_dat_i[0] && loop_closed_i
    && s_q.snap == DBRC_IDLE |=> !loop_ready_flag_o)
    else $error("ready not cleared by sync");
  a_capture_sets_rdy: assert property (s_q.snap == DBRC_CAPT |=> loop_ready_flag_o
    && s_q.ratio.ratio_error == $past(loop_ratio_error_i))
    else $error("snapshot not captured");
  a_bod_decode: assert property (s_q.brownout_control.ctrl == DBRC_BOD_IRQ |-> bod_enable_o && !bod_reset_en_o)
    else $error("bad brownout decode");
  a_flash_cal_unlock: assert property (flash_cal_i |=> !s_q.brownout_control.store_final_lock)
    else $error("lock not cleared by flash calibration");
  a_mask_blocks_por: assert property (s_q.vreg.core_detector_mask |-> !core_por_o)
    else $error("masked detector reset leaked");
  a_deep_disable: assert property (s_q.vreg.deep_mode_disable |-> !vreg_deep_o)
    else $error("deep mode while disabled");
  c_snapshot: cover property (s_q.snap == DBRC_WAIT ##[1:20] loop_ready_flag_o);
  c_bod_lock: cover property (s_q.brownout_control.store_final_lock && wr && wb_adr_i == DBRC_OFF_BOD);
  c_vreg_read: cover property (wb_ack_o && !wb_we_i && wb_adr_i == DBRC_OFF_VREG);
endmodule // dbrc_regs
